// [fpc_cmd.sv]
// Purpose: power, configuration, save/restore, lock and format-write commands
// Assumes: apb master with zero-wait access, one clock
// Notes:   command bytes are written and result bytes read at the data offset
`timescale 1ns/100ps
`include "fpc_defs.svh"
module fpc_cmd
  import fpc_pkg::*;
#(
  parameter int unsigned  TEN_MS_CYC  = (`FPC_T_10MS_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS,
  parameter int unsigned  HALF_S_CYC  = (`FPC_T_HALFS_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS,
  parameter logic [2:0]   PART_FAMILY = 3'h5, // arbitrary value
  parameter logic [4:0]   PART_STEP   = 5'h0a // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [2:0]       precomp_sel,
  output logic [1:0]       data_rate_bits,
  output logic             fifo_enable,
  output logic [3:0]       queue_threshold,
  output logic [7:0]       precomp_start_track,
  output logic             iso_format_select,
  output logic [7:0]       idx_gap4a_len,
  output logic [7:0]       idx_sync_len,
  output logic [7:0]       idx_mark_len,
  output logic [7:0]       gap1_len,
  output logic             powerdown_status,
  output logic             drive_if_float,
  output logic [7:0]       fmt_byte,
  output logic             fmt_byte_valid,
  output logic             fmt_byte_is_id
);
  localparam int unsigned TW = 27;
  if (TEN_MS_CYC == 0 || HALF_S_CYC == 0 || HALF_S_CYC + TEN_MS_CYC >= 2**TW) begin : g_chk
    $error("fpc_cmd: timer counts out of range");
  end

  // ----------------------------------------
  // opcode decode, shared by sequencer and answers
  // ----------------------------------------
  function automatic logic [4:0] op_params(input fpc_byte_t op);
    unique case (op)
      `FPC_OP_SPEC:    op_params = 5'd2;
      `FPC_OP_CONF:    op_params = 5'd3;
      `FPC_OP_PERP,
      `FPC_OP_PWRDN,
      `FPC_OP_OPTION:  op_params = 5'd1;
      `FPC_OP_RESTORE: op_params = `FPC_IMG_LEN;
      `FPC_OP_FMTWR:   op_params = 5'd5;
      default:         op_params = 5'd0;
    endcase
  endfunction

  function automatic logic [4:0] op_results(input fpc_byte_t op);
    if (op[6:0] == `FPC_OP_LOCK) begin
      op_results = 5'd1;
    end else begin
      unique case (op)
        `FPC_OP_SPEC, `FPC_OP_CONF, `FPC_OP_PERP,
        `FPC_OP_OPTION, `FPC_OP_RESTORE: op_results = 5'd0;
        `FPC_OP_SAVE:  op_results = `FPC_IMG_LEN;
        `FPC_OP_FMTWR: op_results = `FPC_FMT_RES;
        default:       op_results = 5'd1;
      endcase
    end
  endfunction

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  fpc_state_t  state_r;
  fpc_byte_t   opc_r;
  fpc_byte_t   par_mem [16];
  fpc_byte_t   fmt_id_r [4];
  fpc_byte_t   res_byte;
  fpc_byte_t   save_img [16];
  fpc_byte_t   dout_r;
  fpc_byte_t   spec0_r, spec1_r, img8_r, img13_r, precomp_start_track_r;
  fpc_byte_t   pcn_r [4];
  logic [4:0]  par_cnt_r, res_idx_r, res_len_r;
  logic [1:0]  id_cnt_r, rate_r, tape_r, boot_r;
  logic [2:0]  pcomp_r;
  logic [3:0]  pdrv_r, thr_r;
  logic [7:0]  sec_cnt_r;
  logic [14:0] byte_left_r;
  logic [TW-1:0] cnt_r, full_cnt;
  logic        c48_r, osc_r, auto_r, ereg_r, fdi_r, mind_r;
  logic        gap_r, wg_r, lock_r, fifo_r, iso_r, armed_r, ext_used_r;
  logic        wr, rd, setup, mapped, soft_rst, exec, rate_chg, idle, expired;

  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite;
  assign rd     = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign mapped = paddr == `FPC_OFF_DATA || paddr == `FPC_OFF_STAT ||
                  paddr == `FPC_OFF_RATE || paddr == `FPC_OFF_DOUT ||
                  paddr == `FPC_OFF_STB  || paddr == `FPC_OFF_TAPE;
  assign pslverr = psel & penable & ~mapped;
  // software reset: reset bit low in the output register or reset bit in the rate register
  assign soft_rst = wr & ((paddr == `FPC_OFF_DOUT & ~pwdata[`FPC_DOUT_RSTN]) |
                          (paddr == `FPC_OFF_RATE & pwdata[`FPC_RATE_SWR]));
  assign exec     = state_r == FPC_EXEC;
  assign idle     = state_r == FPC_OPC;

  // read data is captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      unique case (paddr)
        `FPC_OFF_DATA: prdata <= {24'h0, (state_r == FPC_RESULT) ? res_byte : 8'h00};
        `FPC_OFF_STAT: prdata <= {27'h0, armed_r & ~expired, powerdown_status,
                                  state_r == FPC_FMT_ID || state_r == FPC_FMT_DATA,
                                  state_r == FPC_RESULT, ~idle};
        `FPC_OFF_RATE: prdata <= {24'h0, 1'b0, osc_r, c48_r, pcomp_r, rate_r};
        `FPC_OFF_DOUT: prdata <= {24'h0, dout_r};
        `FPC_OFF_STB:  prdata <= ereg_r ? {24'h0, powerdown_status, idle, drive_if_float,
                                           3'h0, dout_r[1:0]} : {30'h0, dout_r[1:0]};
        `FPC_OFF_TAPE: prdata <= ereg_r ? {24'h0, powerdown_status, idle, 2'h0,
                                           boot_r, tape_r} : {30'h0, tape_r};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    fmt_byte_valid <= 1'b0;
    if (!rst_n) begin
      state_r        <= FPC_OPC;
      opc_r          <= 8'h00;
      par_cnt_r      <= 5'd0;
      res_idx_r      <= 5'd0;
      res_len_r      <= 5'd0;
      id_cnt_r       <= 2'd0;
      sec_cnt_r      <= 8'h00;
      byte_left_r    <= 15'h0000;
      fmt_byte       <= 8'h00;
      fmt_byte_is_id <= 1'b0;
      for (int i = 0; i < 4; i++) fmt_id_r[i] <= 8'h00;
      for (int i = 0; i < 16; i++) par_mem[i] <= 8'h00;
    end else if (soft_rst) begin
      state_r <= FPC_OPC; // a pending command is dropped
    end else begin
      unique case (state_r)
        FPC_OPC: if (wr && paddr == `FPC_OFF_DATA) begin
          opc_r     <= pwdata[7:0];
          par_cnt_r <= 5'd0;
          state_r   <= (op_params(pwdata[7:0]) == 5'd0) ? FPC_EXEC : FPC_PARAM;
        end
        FPC_PARAM: if (wr && paddr == `FPC_OFF_DATA) begin
          par_mem[par_cnt_r[3:0]] <= pwdata[7:0];
          par_cnt_r <= par_cnt_r + 5'd1;
          if (par_cnt_r + 5'd1 == op_params(opc_r)) state_r <= FPC_EXEC;
        end
        FPC_EXEC: begin
          res_idx_r <= 5'd0;
          res_len_r <= op_results(opc_r);
          sec_cnt_r <= 8'h00;
          id_cnt_r  <= 2'd0;
          // fill byte par_mem[4] is never looked at
          if (opc_r == `FPC_OP_FMTWR && par_mem[2] != 8'h00) state_r <= FPC_FMT_ID;
          else if (op_results(opc_r) != 5'd0) state_r <= FPC_RESULT;
          else state_r <= FPC_OPC;
        end
        FPC_FMT_ID: if (wr && paddr == `FPC_OFF_DATA) begin
          fmt_id_r[id_cnt_r] <= pwdata[7:0];
          fmt_byte       <= pwdata[7:0];
          fmt_byte_valid <= 1'b1;
          fmt_byte_is_id <= 1'b1;
          id_cnt_r       <= id_cnt_r + 2'd1;
          if (id_cnt_r == 2'd3) begin
            byte_left_r <= 15'h0080 << pwdata[2:0];
            state_r     <= FPC_FMT_DATA;
          end
        end
        FPC_FMT_DATA: if (wr && paddr == `FPC_OFF_DATA) begin
          fmt_byte       <= pwdata[7:0];
          fmt_byte_valid <= 1'b1;
          fmt_byte_is_id <= 1'b0;
          byte_left_r    <= byte_left_r - 15'h0001;
          if (byte_left_r == 15'h0001) begin
            sec_cnt_r <= sec_cnt_r + 8'h01;
            // whole track: keep going until the sector count is reached
            state_r   <= (sec_cnt_r + 8'h01 == par_mem[2]) ? FPC_RESULT : FPC_FMT_ID;
          end
        end
        FPC_RESULT: if (rd && paddr == `FPC_OFF_DATA) begin
          res_idx_r <= res_idx_r + 5'd1;
          if (res_idx_r + 5'd1 == res_len_r) state_r <= FPC_OPC;
        end
      endcase
    end
  end

  // ----------------------------------------
  // save image and result bytes
  // ----------------------------------------
  always_comb begin
    save_img[0]  = {1'b0, osc_r, 1'b0, pcomp_r, rate_r};
    save_img[1]  = {7'h00, iso_r};
    for (int i = 0; i < 4; i++) save_img[2 + i] = pcn_r[i];
    save_img[6]  = spec0_r;
    save_img[7]  = spec1_r;
    save_img[8]  = img8_r;
    save_img[9]  = {lock_r, 1'b0, pdrv_r, gap_r, wg_r};
    save_img[10] = {2'h0, fifo_r, 1'b0, thr_r};
    save_img[11] = precomp_start_track_r;
    save_img[12] = {4'h0, mind_r, fdi_r, ereg_r, auto_r};
    save_img[13] = img13_r;
    save_img[14] = 8'h00;
    save_img[15] = 8'h00;
  end

  always_comb begin
    res_byte = `FPC_ST0_INVAL;
    if (opc_r[6:0] == `FPC_OP_LOCK) res_byte = {3'h0, lock_r, 4'h0};
    else if (opc_r == `FPC_OP_SAVE) res_byte = save_img[res_idx_r[3:0]];
    else if (opc_r == `FPC_OP_PARTID) res_byte = {PART_FAMILY, PART_STEP};
    else if (opc_r == `FPC_OP_PWRDN) res_byte = save_img[12];
    else if (opc_r == `FPC_OP_FMTWR) begin
      if (res_idx_r == 5'd0) res_byte = {5'h00, par_mem[0][2:0]};
      else if (res_idx_r < 5'd3) res_byte = 8'h00;
      else res_byte = fmt_id_r[2'(res_idx_r - 5'd3)];
    end
  end

  // ----------------------------------------
  // rate, output and tape registers
  // ----------------------------------------
  assign rate_chg = (wr && paddr == `FPC_OFF_RATE && pwdata[1:0] != rate_r) ||
                    (exec && opc_r == `FPC_OP_RESTORE && par_mem[0][1:0] != rate_r);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_r <= 2'h0;
      pcomp_r <= 3'h0;
      c48_r <= 1'b0;
      osc_r <= 1'b0;
    end else if (wr && paddr == `FPC_OFF_RATE) begin
      rate_r  <= pwdata[1:0];
      pcomp_r <= pwdata[`FPC_RATE_PC_HI:`FPC_RATE_PC_LO];
      c48_r   <= pwdata[`FPC_RATE_C48];
      osc_r   <= pwdata[`FPC_RATE_OSC];
    end else if (exec && opc_r == `FPC_OP_RESTORE) begin
      rate_r  <= par_mem[0][1:0];
      pcomp_r <= par_mem[0][`FPC_RATE_PC_HI:`FPC_RATE_PC_LO];
      osc_r   <= par_mem[0][`FPC_RATE_OSC];
    end
  end

  // boot select bits only take writes while the extended registers are on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout_r <= `FPC_DOUT_RST;
      tape_r <= 2'h0;
      boot_r <= 2'h0;
    end else if (wr && paddr == `FPC_OFF_DOUT) begin
      dout_r <= pwdata[7:0];
    end else if (wr && paddr == `FPC_OFF_TAPE) begin
      tape_r <= pwdata[1:0];
      if (ereg_r) boot_r <= pwdata[3:2];
    end
  end

  // ----------------------------------------
  // powerdown parameters: hardware reset only
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      auto_r <= 1'b0;
      ereg_r <= 1'b0;
      fdi_r  <= 1'b0;
      mind_r <= 1'b0;
    end else if (exec && (opc_r == `FPC_OP_PWRDN || opc_r == `FPC_OP_RESTORE)) begin
      // software reset is not a term here, so the settings survive it
      auto_r <= par_mem[opc_r == `FPC_OP_PWRDN ? 0 : 12][`FPC_PD_AUTO];
      ereg_r <= par_mem[opc_r == `FPC_OP_PWRDN ? 0 : 12][`FPC_PD_EREG];
      fdi_r  <= par_mem[opc_r == `FPC_OP_PWRDN ? 0 : 12][`FPC_PD_FDI];
      mind_r <= par_mem[opc_r == `FPC_OP_PWRDN ? 0 : 12][`FPC_PD_MIN];
    end
  end

  // ----------------------------------------
  // configure, lock, perpendicular, option, specify, cylinders
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_r   <= 1'b0;
      fifo_r   <= `FPC_FIFO_RST;
      thr_r    <= `FPC_THR_RST;
      precomp_start_track_r <= `FPC_PRECOMP_START_TRACK_RST;
      gap_r    <= 1'b0;
      wg_r     <= 1'b0;
      pdrv_r   <= 4'h0;
      iso_r    <= 1'b0;
      spec0_r  <= 8'h00;
      spec1_r  <= 8'h00;
      img8_r   <= 8'h00;
      img13_r  <= 8'h00;
      for (int i = 0; i < 4; i++) pcn_r[i] <= 8'h00;
    end else if (soft_rst) begin
      gap_r <= 1'b0;
      wg_r  <= 1'b0;
      if (!lock_r) begin
        fifo_r   <= `FPC_FIFO_RST;
        thr_r    <= `FPC_THR_RST;
        precomp_start_track_r <= `FPC_PRECOMP_START_TRACK_RST;
      end
    end else if (exec) begin
      if (opc_r[6:0] == `FPC_OP_LOCK) lock_r <= opc_r[7];
      if (opc_r == `FPC_OP_CONF) begin
        fifo_r   <= par_mem[1][`FPC_CF_FIFO];
        thr_r    <= par_mem[1][3:0];
        precomp_start_track_r <= par_mem[2];
      end
      if (opc_r == `FPC_OP_PERP) begin
        wg_r  <= par_mem[0][`FPC_PP_WG];
        gap_r <= par_mem[0][`FPC_PP_GAP];
        if (par_mem[0][`FPC_PP_OW]) pdrv_r <= par_mem[0][5:2];
      end
      if (opc_r == `FPC_OP_OPTION) iso_r <= par_mem[0][0];
      if (opc_r == `FPC_OP_SPEC) begin
        spec0_r <= par_mem[0];
        spec1_r <= par_mem[1];
      end
      if (opc_r == `FPC_OP_RESTORE) begin
        iso_r    <= par_mem[1][0];
        for (int i = 0; i < 4; i++) pcn_r[i] <= par_mem[2 + i];
        spec0_r  <= par_mem[6];
        spec1_r  <= par_mem[7];
        img8_r   <= par_mem[8];
        lock_r   <= par_mem[9][7];
        pdrv_r   <= par_mem[9][5:2];
        gap_r    <= par_mem[9][1];
        wg_r     <= par_mem[9][0];
        fifo_r   <= par_mem[10][`FPC_CF_FIFO];
        thr_r    <= par_mem[10][3:0];
        precomp_start_track_r <= par_mem[11];
        img13_r  <= par_mem[13];
      end
    end
  end

  // ----------------------------------------
  // minimum power-up timer
  // ----------------------------------------
  always_comb begin
    logic msel;
    msel = mind_r;
    if (exec && opc_r == `FPC_OP_PWRDN) msel = par_mem[0][`FPC_PD_MIN];
    if (exec && opc_r == `FPC_OP_RESTORE) msel = par_mem[12][`FPC_PD_MIN];
    full_cnt = msel ? TW'(HALF_S_CYC) : TW'(TEN_MS_CYC);
  end
  assign expired = armed_r & (cnt_r == '0);

  // a single extension per countdown keeps the total stretch within 10 ms
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r      <= '0;
      armed_r    <= 1'b0;
      ext_used_r <= 1'b0;
    end else if (soft_rst || (exec && (opc_r == `FPC_OP_PWRDN || opc_r == `FPC_OP_RESTORE))) begin
      cnt_r      <= full_cnt;
      ext_used_r <= 1'b0;
      if (!soft_rst) armed_r <= 1'b1;
    end else if (cnt_r != '0) begin
      if (rate_chg && !ext_used_r) begin
        cnt_r      <= cnt_r - TW'(1) + TW'(TEN_MS_CYC);
        ext_used_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r - TW'(1);
      end
    end
  end

  // sleep needs auto powerdown on, the timer run out and no command in flight
  always_ff @(posedge clk) begin
    if (!rst_n) powerdown_status <= 1'b0;
    else powerdown_status <= auto_r & expired & idle & ~soft_rst;
  end

  // ----------------------------------------
  // drive-side outputs
  // ----------------------------------------
  assign drive_if_float = powerdown_status & ~fdi_r;
  // perpendicular drives write with zero precompensation unless gap or write-gate is set
  assign precomp_sel = (gap_r | wg_r | ~pdrv_r[dout_r[1:0]]) ? pcomp_r : 3'h0;
  assign data_rate_bits      = rate_r;
  assign fifo_enable         = fifo_r;
  assign queue_threshold     = thr_r;
  assign precomp_start_track = precomp_start_track_r;
  assign iso_format_select   = iso_r;
  assign idx_gap4a_len = iso_r ? 8'h00 : `FPC_GAP4A_LEN;
  assign idx_sync_len  = iso_r ? 8'h00 : `FPC_SYNC_LEN;
  assign idx_mark_len  = iso_r ? 8'h00 : `FPC_MARK_LEN;
  assign gap1_len      = iso_r ? `FPC_GAP1_ISO : `FPC_GAP1_LEN;
endmodule

// [fpc_cmd_assertions.sv]
// Purpose: concurrent checks on the power and configuration commands
// Assumes: bound to the top module, one clock, synchronous reset
// Notes:   timer state is judged from the powerdown output only
`timescale 1ns/100ps
module fpc_cmd_assertions (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        fifo_enable,
  input wire logic [3:0]  queue_threshold,
  input wire logic [7:0]  precomp_start_track,
  input wire logic        iso_format_select,
  input wire logic [7:0]  idx_gap4a_len,
  input wire logic [7:0]  idx_sync_len,
  input wire logic [7:0]  idx_mark_len,
  input wire logic [7:0]  gap1_len,
  input wire logic        powerdown_status,
  input wire logic        drive_if_float,
  input wire logic        fmt_byte_valid
);
  logic wr_d1_r;
  logic wr_d2_r;
  // delayed write strobes: command effects land one or two cycles after the write
  always_ff @(posedge clk) begin
    wr_d1_r <= psel && penable && pwrite;
    wr_d2_r <= wr_d1_r;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_STD_GAPS: assert property (!iso_format_select |->
    {idx_gap4a_len, idx_sync_len, idx_mark_len, gap1_len} == 32'h500c0432)
    else $error("standard index lengths wrong");
  AST_ISO_GAP: assert property (iso_format_select |-> gap1_len == 8'h20)
    else $error("iso gap length wrong");
  AST_FLOAT: assert property (drive_if_float |-> powerdown_status)
    else $error("drive float outside powerdown");
  AST_HW_RST: assert property ($rose(rst_n) |-> !powerdown_status && !fifo_enable
    && queue_threshold == 4'h0 && precomp_start_track == 8'h00)
    else $error("hardware reset values wrong");
  AST_FMT_SRC: assert property (fmt_byte_valid |-> wr_d1_r && $past(paddr) == 8'h00)
    else $error("format byte without data write");
  AST_FMT_PULSE: assert property (fmt_byte_valid |=> !fmt_byte_valid)
    else $error("format strobe longer than one cycle");
  AST_SRST_TMR: assert property ((psel && penable && pwrite && paddr == 8'h0c
    && !pwdata[2]) |-> ##2 !powerdown_status [*8])
    else $error("powerdown soon after software reset");
  AST_LOCK_KEEP: assert property (($past(rst_n) &&
    $changed({fifo_enable, queue_threshold, precomp_start_track})) |-> wr_d1_r || wr_d2_r)
    else $error("fifo settings changed with no write");
endmodule
bind fpc_cmd fpc_cmd_assertions fpc_cmd_assertions_i (.clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .fifo_enable, .queue_threshold, .precomp_start_track, .iso_format_select,
  .idx_gap4a_len, .idx_sync_len, .idx_mark_len, .gap1_len, .powerdown_status,
  .drive_if_float, .fmt_byte_valid);

// [fpc_defs.svh]
// Purpose: offsets, field positions, reset values, opcodes and times
// Assumes: 32-bit apb data, 8-bit offsets, byte-wide registers
// Notes:   included by the power/config command block only
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FPC_OFF_DATA 8'h00
`define FPC_OFF_STAT 8'h04
`define FPC_OFF_RATE 8'h08
`define FPC_OFF_DOUT 8'h0c
`define FPC_OFF_STB  8'h10
`define FPC_OFF_TAPE 8'h14
// ----------------------------------------
// field positions
// ----------------------------------------
`define FPC_RATE_PC_LO 2
`define FPC_RATE_PC_HI 4
`define FPC_RATE_C48   5
`define FPC_RATE_OSC   6
`define FPC_RATE_SWR   7
`define FPC_DOUT_RSTN  2
`define FPC_PD_AUTO    0
`define FPC_PD_EREG    1
`define FPC_PD_FDI     2
`define FPC_PD_MIN     3
`define FPC_PP_WG      0
`define FPC_PP_GAP     1
`define FPC_PP_OW      7
`define FPC_CF_FIFO    5
// ----------------------------------------
// reset values
// ----------------------------------------
`define FPC_FIFO_RST   1'b0
`define FPC_THR_RST    4'h0
`define FPC_PRECOMP_START_TRACK_RST 8'h00
`define FPC_DOUT_RST   8'h04
// ----------------------------------------
// opcodes, answers, format lengths
// ----------------------------------------
`define FPC_OP_SPEC    8'h03
`define FPC_OP_PERP    8'h12
`define FPC_OP_CONF    8'h13
`define FPC_OP_LOCK    7'h14
`define FPC_OP_PARTID  8'h18
`define FPC_OP_PWRDN   8'h27
`define FPC_OP_SAVE    8'h2e
`define FPC_OP_OPTION  8'h33
`define FPC_OP_RESTORE 8'h4e
`define FPC_OP_FMTWR   8'hef
`define FPC_ST0_INVAL  8'h80
`define FPC_IMG_LEN    5'h10
`define FPC_FMT_RES    5'h07
`define FPC_GAP4A_LEN  8'h50
`define FPC_SYNC_LEN   8'h0c
`define FPC_MARK_LEN   8'h04
`define FPC_GAP1_LEN   8'h32
`define FPC_GAP1_ISO   8'h20
// ----------------------------------------
// times
// ----------------------------------------
`define FPC_CLK_NS     5
`define FPC_T_10MS_NS  10000000
`define FPC_T_HALFS_NS 500000000
`define FPC_T_RST_US   20
`endif

// [fpc_host.sv]
// Purpose: host model, an apb master that issues command bytes
// Assumes: the slave answers whenever pready is high at an edge
// Notes:   released address and data lines are inverted so stale use shows up
`timescale 1ns/100ps
module fpc_host (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  logic err;
  initial {psel, penable, pwrite, paddr, pwdata, err} = '0;
  // one transfer: setup cycle, then access held until pready is seen
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~{24'h0, d};
  endtask
endmodule

// [fpc_pkg.sv]
// Purpose: types shared by the power/config command block
// Assumes: nothing
// Notes:   constants live in fpc_defs.svh
package fpc_pkg;
  typedef enum logic [2:0] {
    FPC_OPC, FPC_PARAM, FPC_EXEC, FPC_FMT_ID, FPC_FMT_DATA, FPC_RESULT
  } fpc_state_t;
  typedef logic [7:0] fpc_byte_t;
endpackage

// [tb_fpc_power_config_commands.sv]
// Purpose: self-checking bench for the power and configuration commands
// Assumes: short timer counts, host model on apb
// Notes:   expected bytes follow the command layouts
`timescale 1ns/100ps
module tb_fpc_power_config_commands;
  localparam int TEN  = 20;
  localparam int HALF = 50;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, fifo_enable, iso_format_select;
  logic        powerdown_status, drive_if_float, fmt_byte_valid, fmt_byte_is_id;
  logic [1:0]  data_rate_bits;
  logic [2:0]  precomp_sel;
  logic [3:0]  queue_threshold;
  logic [7:0]  paddr, precomp_start_track, idx_gap4a_len, idx_sync_len, idx_mark_len;
  logic [7:0]  gap1_len, fmt_byte, q, p, t, k;
  logic [7:0]  img [16];
  logic [31:0] pwdata, prdata;
  int          miscompares = 0, tests_run = 0, seed = 16, nid = 0, ndat = 0, lim;
  always #2.5 clk = ~clk;
  fpc_cmd #(.TEN_MS_CYC(TEN), .HALF_S_CYC(HALF)) fpc_cmd_i (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .precomp_sel, .data_rate_bits,
    .fifo_enable, .queue_threshold, .precomp_start_track, .iso_format_select,
    .idx_gap4a_len, .idx_sync_len, .idx_mark_len, .gap1_len, .powerdown_status,
    .drive_if_float, .fmt_byte, .fmt_byte_valid, .fmt_byte_is_id);
  fpc_host fpc_host_i (.clk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
    .pwdata);
  // tally streamed format bytes by kind
  always @(posedge clk) begin
    if (fmt_byte_valid === 1'b1 && fmt_byte_is_id === 1'b1) nid++;
    if (fmt_byte_valid === 1'b1 && fmt_byte_is_id === 1'b0) ndat++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [7:0] d);
    fpc_host_i.xfer(1'b1, 8'h00, d, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    fpc_host_i.xfer(1'b1, a, d, q);
  endtask
  // poll for a ready result, bounded, then pop it
  task automatic rdr(output logic [7:0] r);
    int n;
    n = 0;
    do begin
      fpc_host_i.xfer(1'b0, 8'h04, 8'h00, r);
      n++;
    end while (r[1] !== 1'b1 && n < 50);
    fpc_host_i.xfer(1'b0, 8'h00, 8'h00, r);
  endtask
  task automatic res(input logic [7:0] e);
    rdr(q);
    chk(q, e);
  endtask
  task automatic wt;
    repeat (3) @(negedge clk);
  endtask
  // the count is taken from the bench, so a stuck timer times out here
  task automatic pdwait(input int lo, input int hi);
    int n;
    n = 0;
    while (powerdown_status !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({fifo_enable, queue_threshold, precomp_start_track, powerdown_status}, 0);
    chk({idx_gap4a_len, idx_sync_len, idx_mark_len, gap1_len}, 32'h500c0432);
    fpc_host_i.xfer(1'b0, 8'h20, 8'h00, q);
    chk({fpc_host_i.err, q}, 9'h100);
    wb(8'h18);
    res({3'h5, 5'h0a});
    p = (8'($random(seed)) & 8'h0f) | 8'h01;
    lim = p[3] ? HALF : TEN;
    wb(8'h27);
    wb(p);
    res(p);
    pdwait(lim - 12, lim);
    chk(drive_if_float, !p[2]);
    fpc_host_i.xfer(1'b0, 8'h10, 8'h00, q);
    chk(q, p[1] ? {2'b11, !p[2], 5'h00} : 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h0c, 8'h04);
    wr(8'h08, 8'h01);
    pdwait(lim + TEN - 10, lim + TEN + 1);
    chk(data_rate_bits, 2'h1);
    wr(8'h08, 8'h14);
    wb(8'h12);
    wb(8'h83);
    wt;
    chk(precomp_sel, 3'h5);
    wb(8'h12);
    wb(8'h84);
    wt;
    chk(precomp_sel, 3'h0);
    t = 8'($random(seed)) & 8'h2f;
    k = 8'($random(seed));
    wb(8'h13);
    wb(8'h00);
    wb(t);
    wb(k);
    wb(8'h94);
    res(8'h10);
    wr(8'h08, 8'h94);
    wt;
    chk({fifo_enable, queue_threshold, precomp_start_track}, {t[5], t[3:0], k});
    wb(8'h14);
    res(8'h00);
    wr(8'h08, 8'h94);
    wt;
    chk({fifo_enable, queue_threshold, precomp_start_track}, 0);
    wb(8'h33);
    wb(8'h01);
    wt;
    chk({idx_gap4a_len, idx_sync_len, idx_mark_len, gap1_len}, 32'h00000020);
    wb(8'h2e);
    for (int i = 0; i < 16; i++) rdr(img[i]);
    chk({img[0], img[1], img[12]}, {8'h14, 8'h01, 4'h0, p[3:0]});
    chk({img[14], img[15]}, 0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({powerdown_status, iso_format_select}, 0);
    wb(8'h03);
    wb(8'h11);
    wb(8'h22);
    wb(8'h4e);
    for (int i = 0; i < 16; i++) wb(img[i]);
    repeat (4000) @(posedge clk);
    wb(8'h2e);
    // a save after the restore must give back the same 16 image bytes
    for (int i = 0; i < 16; i++) res(img[i]);
    wb(8'hef);
    wb(8'h00);
    wb(8'h00);
    wb(8'h01);
    wb(8'h1b);
    wb(8'he5);
    for (int i = 0; i < 132; i++) wb(i == 0 ? 8'h05 : i == 2 ? 8'h07 : i < 4 ? 8'h00 : 8'(i));
    for (int i = 0; i < 7; i++) res(i == 3 ? 8'h05 : i == 5 ? 8'h07 : 8'h00);
    chk(nid, 4);
    chk(ndat, 128);
    chk(fmt_byte, 8'h83);
    finish_test;
  end
  initial begin
    #500000;
    miscompares++;
    finish_test;
  end
endmodule
